// ===== hdl/spa_pkg.sv
// Package: constants and types shared by both ends of the storage port adapter
package spa_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESP_DELAY_NS = 150;
  // Approximate delay, rounded down to whole cycles, never below one
  localparam int RESP_DELAY_CYC = (RESP_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (RESP_DELAY_NS / CLK_PERIOD_NS);
  localparam int ACCEPT_LEAD_CYC = 1;
  localparam int RESP_HOLD_CYC = 12;
  localparam int ADV_PULSE_CYC = 10;
  localparam int DATA_HOLD_CYC = 22;
  localparam int CNT_W = 6;

  // ************************************************************
  // Widths and reset values
  // ************************************************************
  localparam int DATA_W = 72;
  localparam int ADDR_W = 24;
  localparam int SUBCH_N = 4;
  localparam int CHK_W = 4;
  localparam int FIFO_DEPTH = 32;
  localparam logic [CNT_W-1:0] CNT_RST = 6'h00;

  // ************************************************************
  // Check indication bit positions
  // ************************************************************
  localparam int CHK_ADDR = 0;
  localparam int CHK_INVALID = 1;
  localparam int CHK_DATA = 2;
  localparam int CHK_PROT = 3;

  typedef enum logic [2:0] {
    SPA_CH_IDLE = 3'b000,
    SPA_CH_REQ = 3'b001,
    SPA_CH_WAIT = 3'b010,
    SPA_CH_DONE = 3'b011
  } spa_ch_state_t;

  typedef enum logic [2:0] {
    SPA_SE_IDLE = 3'b000,
    SPA_SE_ACCEPT = 3'b001,
    SPA_SE_RESP = 3'b010,
    SPA_SE_ADV = 3'b011,
    SPA_SE_HOLD = 3'b100
  } spa_se_state_t;

endpackage : spa_pkg

// ===== hdl/spa_link_if.sv
// Interface: storage-side lines between channel and storage control element
`timescale 1ns/1ns
interface spa_link_if;
  import spa_pkg::*;
  logic storage_request;
  logic store;
  logic address_valid;
  logic [ADDR_W-1:0] storage_addr;
  logic [DATA_W-1:0] storage_bus_out;
  logic [DATA_W-1:0] storage_bus_in;
  logic subchannel_in_operation;
  logic accept;
  logic storage_response;
  logic advance_pulse;
  logic [CHK_W-1:0] storage_check;

  modport channel (
    output storage_request, store, address_valid, storage_addr, storage_bus_in,
    output subchannel_in_operation,
    input accept, storage_response, advance_pulse, storage_bus_out, storage_check
  );
  modport sce (
    input storage_request, store, address_valid, storage_addr, storage_bus_in,
    input subchannel_in_operation,
    output accept, storage_response, advance_pulse, storage_bus_out, storage_check
  );
endinterface : spa_link_if

// ===== hdl/spa_fifo.sv
// FIFO: parameterised width and depth, valid/ready on both sides
`timescale 1ns/1ns
module spa_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : spa_fifo

// ===== hdl/spa_channel_end.sv
// Channel end: storage port adapter logic on the multiplexer channel side
`timescale 1ns/1ns
module spa_channel_end
  import spa_pkg::*;
#(
  parameter int SUBCH = SUBCH_N
) (
  input wire logic clk,
  input wire logic sys_rst,
  spa_link_if.channel link,
  // Subchannel tracking
  input wire logic [SUBCH-1:0] sel_start,
  input wire logic [SUBCH-1:0] int_accepted,
  output logic [SUBCH-1:0] selector_subchannel_busy,
  // Storage request from the channel core
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_store,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  // Data-request strobe to the channel core
  output logic storage_data_request,
  // Fetched data and checks through the FIFO
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DATA_W-1:0] rd_data,
  output logic [CHK_W-1:0] rd_check
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    spa_ch_state_t st;
    logic [SUBCH-1:0] busy;
    logic [RESP_DELAY_CYC-1:0] resp_dly;
    logic resp_dly_prev;
    logic dreq;
    logic [2:0] adv_sync;
    logic [1:0] resp_sync;
    logic store;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic cap_valid;
    logic [DATA_W+CHK_W-1:0] cap;
  } spa_ch_t;

  spa_ch_t s_q;
  spa_ch_t s_d;
  logic adv_rise;
  logic resp_s;
  logic fifo_in_ready;
  logic [DATA_W+CHK_W-1:0] fifo_out;

  // Response and advance arrive from another unit: two flip-flops before use
  assign resp_s = s_q.resp_sync[1];
  assign adv_rise = s_q.adv_sync[1] && !s_q.adv_sync[2];

  always_comb begin
    s_d = s_q;
    s_d.resp_sync = {s_q.resp_sync[0], link.storage_response};
    s_d.adv_sync = {s_q.adv_sync[1:0], link.advance_pulse};
    // Set wins over clear when both land together
    s_d.busy = (s_q.busy & ~int_accepted) | sel_start;
    // Response delay line; strobe fires once per rising delayed response
    s_d.resp_dly = {resp_s, s_q.resp_dly[RESP_DELAY_CYC-1:1]};
    s_d.resp_dly_prev = s_q.resp_dly[0];
    s_d.dreq = s_q.resp_dly[0] && !s_q.resp_dly_prev;
    if (s_q.cap_valid && fifo_in_ready) begin
      s_d.cap_valid = 1'b0;
    end
    case (s_q.st)
      SPA_CH_IDLE: begin
        // Only take a request that req_ready has offered
        if (req_valid && fifo_in_ready) begin
          s_d.st = SPA_CH_REQ;
          s_d.store = req_store;
          s_d.addr = req_addr;
          s_d.wdata = req_wdata;
        end
      end
      SPA_CH_REQ: begin
        // Accept may come before the response; wait for the response to rise
        if (resp_s) begin
          s_d.st = SPA_CH_WAIT;
        end
      end
      SPA_CH_WAIT: begin
        if (adv_rise) begin
          // Data and checks are taken here only, never on the earlier strobe
          s_d.cap = {link.storage_check, link.storage_bus_out};
          s_d.cap_valid = !s_q.store;
          s_d.st = SPA_CH_DONE;
        end
      end
      SPA_CH_DONE: begin
        // Long response, data and check hold is tolerated here
        if (!resp_s && !s_q.cap_valid) begin
          s_d.st = SPA_CH_IDLE;
        end
      end
      default: begin
        s_d.st = SPA_CH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Read data buffer
  // ************************************************************
  // The advance pulse cannot be stalled, so a capture waits here and new requests stall
  spa_fifo #(.WIDTH(DATA_W+CHK_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(s_q.cap_valid),
    .in_ready(fifo_in_ready),
    .in_data(s_q.cap),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(fifo_out)
  );
  assign rd_data = fifo_out[DATA_W-1:0];
  assign rd_check = fifo_out[DATA_W+CHK_W-1:DATA_W];

  // ************************************************************
  // Outputs
  // ************************************************************
  // Only the lines listed exist; fault-test, large-core, priority lines absent
  assign link.subchannel_in_operation = |s_q.busy;
  assign link.storage_request = (s_q.st == SPA_CH_REQ);
  assign link.address_valid = (s_q.st == SPA_CH_REQ);
  assign link.store = s_q.store;
  assign link.storage_addr = s_q.addr;
  assign link.storage_bus_in = s_q.wdata;
  assign selector_subchannel_busy = s_q.busy;
  assign storage_data_request = s_q.dreq;
  // Stall new requests while the FIFO has no room for another capture
  assign req_ready = (s_q.st == SPA_CH_IDLE) && fifo_in_ready;
endmodule : spa_channel_end

// ===== hdl/spa_sce_end.sv
// Storage control element end: answers channel storage requests
`timescale 1ns/1ns
module spa_sce_end
  import spa_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  spa_link_if.sce link,
  // Storage-side user port
  output logic mem_valid,
  output logic mem_store,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_wdata,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic [CHK_W-1:0] mem_check,
  output logic chan_active
);
  typedef struct packed {
    spa_se_state_t st;
    logic [CNT_W-1:0] cnt;
    logic accept;
    logic resp;
    logic adv;
    logic [DATA_W-1:0] data;
    logic [CHK_W-1:0] chk;
    logic mem_valid;
    logic [1:0] req_sync;
    logic [1:0] act_sync;
  } spa_se_t;

  spa_se_t s_q;
  spa_se_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.req_sync = {s_q.req_sync[0], link.storage_request};
    s_d.act_sync = {s_q.act_sync[0], link.subchannel_in_operation};
    s_d.mem_valid = 1'b0;
    case (s_q.st)
      SPA_SE_IDLE: begin
        if (s_q.req_sync[1]) begin
          // Accept raised early, ahead of the response
          s_d.accept = 1'b1;
          s_d.cnt = CNT_W'(ACCEPT_LEAD_CYC);
          s_d.st = SPA_SE_ACCEPT;
          s_d.mem_valid = 1'b1;
        end
      end
      SPA_SE_ACCEPT: begin
        s_d.cnt = s_q.cnt - 1'b1;
        if (s_q.cnt == CNT_RST + 1'b1) begin
          // Only the response is sent; no data request line exists
          s_d.resp = 1'b1;
          s_d.cnt = CNT_W'(RESP_HOLD_CYC);
          s_d.st = SPA_SE_RESP;
        end
      end
      SPA_SE_RESP: begin
        s_d.cnt = s_q.cnt - 1'b1;
        if (s_q.cnt == CNT_RST + 1'b1) begin
          s_d.adv = 1'b1;
          s_d.data = link.store ? '0 : mem_rdata;
          s_d.chk = mem_check;
          s_d.cnt = CNT_W'(DATA_HOLD_CYC);
          s_d.st = SPA_SE_ADV;
        end
      end
      SPA_SE_ADV: begin
        s_d.cnt = s_q.cnt - 1'b1;
        if (s_q.cnt == CNT_W'(DATA_HOLD_CYC - ADV_PULSE_CYC)) begin
          s_d.adv = 1'b0;
          // Accept drops together with the response
          s_d.accept = 1'b0;
          s_d.resp = 1'b0;
          s_d.st = SPA_SE_HOLD;
        end
      end
      SPA_SE_HOLD: begin
        s_d.cnt = s_q.cnt - 1'b1;
        if (s_q.cnt == CNT_RST + 1'b1) begin
          // Data and checks stay valid long after the advance pulse
          s_d.data = '0;
          s_d.chk = '0;
          // A request already waiting is taken up from idle, never stalls here
          s_d.st = SPA_SE_IDLE;
        end
      end
      default: begin
        s_d.st = SPA_SE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // No priority or large-core lines are driven by this end
  assign link.accept = s_q.accept;
  assign link.storage_response = s_q.resp;
  assign link.advance_pulse = s_q.adv;
  assign link.storage_bus_out = s_q.data;
  assign link.storage_check = s_q.chk;
  assign mem_valid = s_q.mem_valid;
  assign mem_store = link.store;
  assign mem_addr = link.storage_addr;
  assign mem_wdata = link.storage_bus_in;
  assign chan_active = s_q.act_sync[1];
endmodule : spa_sce_end

// ===== bench/spa_props.sv
// Checker: timing relations on the storage-side link between the two ends
`timescale 1ns/1ns
module spa_props
  import spa_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic storage_request,
  input wire logic accept,
  input wire logic storage_response,
  input wire logic advance_pulse,
  input wire logic [DATA_W-1:0] storage_bus_out,
  input wire logic [CHK_W-1:0] storage_check
);
  // ****************************************
  // Link timing
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_acc_soon; $rose(storage_request) |-> ##[1:10] accept; endproperty
  a_acc_soon: assert property (p_acc_soon) else $error("accept missing after request");
  property p_acc_lead; $rose(storage_response) |-> accept; endproperty
  a_acc_lead: assert property (p_acc_lead) else $error("response rose before accept");
  property p_acc_drop; $fell(accept) |-> $fell(storage_response); endproperty
  a_acc_drop: assert property (p_acc_drop) else $error("accept fell apart from response");
  property p_resp_hold; $rose(storage_response) |-> storage_response [*8]; endproperty
  a_resp_hold: assert property (p_resp_hold) else $error("response too short");
  property p_adv_due; $rose(storage_response) |-> ##[1:20] $rose(advance_pulse); endproperty
  a_adv_due: assert property (p_adv_due) else $error("advance missing after response");
  property p_adv_len; $rose(advance_pulse) |-> advance_pulse [*8]; endproperty
  a_adv_len: assert property (p_adv_len) else $error("advance too short");
  property p_adv_resp; $rose(advance_pulse) |-> storage_response && accept; endproperty
  a_adv_resp: assert property (p_adv_resp) else $error("advance without response");
  // Fetched word must not move while the channel may still be capturing it
  property p_data_hold; advance_pulse && $past(advance_pulse) |-> $stable(storage_bus_out) && $stable(storage_check);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved during advance");
  property p_req_hold; $fell(storage_request) |-> storage_response; endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before response");
endmodule : spa_props

// ===== bench/tb_storage_port_adapter.sv
// Testbench: channel end and storage end joined across the link
`timescale 1ns/1ns
module tb_storage_port_adapter
  import spa_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [SUBCH_N-1:0] sel_start = '0;
  logic [SUBCH_N-1:0] int_accepted = '0;
  logic [SUBCH_N-1:0] busy;
  logic req_valid = 1'b0;
  logic req_ready;
  logic req_store = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic storage_data_request;
  logic rd_valid;
  logic rd_ready = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic [CHK_W-1:0] rd_check;
  logic mem_valid;
  logic mem_store;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_rdata = '0;
  logic [CHK_W-1:0] mem_check = '0;
  logic chan_active;
  logic resp_q = 1'b0;
  logic ok;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int gap = 0;
  int n_dreq = 0;
  int n;

  always #10 clk = ~clk;

  spa_link_if i_spa_link_if ();
  spa_channel_end i_spa_channel_end (.clk(clk), .sys_rst(sys_rst), .link(i_spa_link_if), .sel_start(sel_start),
    .int_accepted(int_accepted), .selector_subchannel_busy(busy), .req_valid(req_valid), .req_ready(req_ready),
    .req_store(req_store), .req_addr(req_addr), .req_wdata(req_wdata), .storage_data_request(storage_data_request),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .rd_check(rd_check));
  spa_sce_end i_spa_sce_end (.clk(clk), .sys_rst(sys_rst), .link(i_spa_link_if), .mem_valid(mem_valid),
    .mem_store(mem_store), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_check(mem_check), .chan_active(chan_active));
  spa_props i_spa_props (.clk(clk), .sys_rst(sys_rst), .storage_request(i_spa_link_if.storage_request),
    .accept(i_spa_link_if.accept), .storage_response(i_spa_link_if.storage_response),
    .advance_pulse(i_spa_link_if.advance_pulse), .storage_bus_out(i_spa_link_if.storage_bus_out),
    .storage_check(i_spa_link_if.storage_check));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : check

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // One storage access; done is low when the channel refused it
  task automatic access(input logic st, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic done);
    int w;
    w = 0;
    req_valid = 1'b1;
    req_store = st;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1 && w < 200) begin
      @(negedge clk);
      w++;
    end
    done = (w < 200);
    @(negedge clk);
    req_valid = 1'b0;
    w = 0;
    while (done && mem_valid !== 1'b1 && w < 50) begin
      @(negedge clk);
      w++;
    end
    if (done) begin
      check(mem_addr, a, "storage address");
      check(mem_store, st, "store flag");
      if (st) check(mem_wdata, d, "store data");
    end
    repeat (40) @(negedge clk);
  endtask : access

  // Data request must trail the response by the configured delay
  always @(negedge clk) begin
    if (i_spa_link_if.storage_response && !resp_q) gap = 0;
    else gap++;
    resp_q = i_spa_link_if.storage_response;
    if (storage_data_request) begin
      n_dreq++;
      check(gap >= RESP_DELAY_CYC && gap <= RESP_DELAY_CYC + 4, 1, "data request delay");
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    for (n = 0; n < SUBCH_N; n++) begin
      sel_start[n] = 1'b1;
      @(negedge clk);
      sel_start[n] = 1'b0;
      repeat (4) @(negedge clk);
      check(busy, SUBCH_N'(1) << n, "busy after selection");
      check(i_spa_link_if.subchannel_in_operation, 1, "in operation set");
      check(chan_active, 1, "storage end sees operation");
      sel_start[n] = 1'b1;
      int_accepted[n] = 1'b1;
      @(negedge clk);
      sel_start[n] = 1'b0;
      int_accepted[n] = 1'b0;
      repeat (2) @(negedge clk);
      check(busy[n], 1, "busy kept on same-cycle set");
      int_accepted[n] = 1'b1;
      @(negedge clk);
      int_accepted[n] = 1'b0;
      repeat (4) @(negedge clk);
      check(i_spa_link_if.subchannel_in_operation, 0, "in operation cleared");
      check(chan_active, 0, "storage end sees idle");
    end
    sel_start = '1;
    @(negedge clk);
    sel_start = '0;
    int_accepted = SUBCH_N'(1);
    @(negedge clk);
    int_accepted = '0;
    repeat (2) @(negedge clk);
    check(i_spa_link_if.subchannel_in_operation, 1, "in operation with others busy");
    int_accepted = '1;
    @(negedge clk);
    int_accepted = '0;
    repeat (2) @(negedge clk);
    check(i_spa_link_if.subchannel_in_operation, 0, "in operation all idle");
    // Fill the buffer with the reader stalled, then drain it in order
    for (n = 0; n < FIFO_DEPTH + 4; n++) begin
      mem_rdata = {9{n[7:0]}};
      mem_check = n[3:0];
      access(1'b0, ADDR_W'(n), '0, ok);
      if (!ok) break;
    end
    check(n, FIFO_DEPTH, "words accepted before full");
    rd_ready = 1'b1;
    for (n = 0; n < FIFO_DEPTH; n++) begin
      check(rd_valid, 1, "word waiting");
      check(rd_data, {9{n[7:0]}}, "fetched data");
      check(rd_check, n[3:0], "check bits");
      @(negedge clk);
    end
    check(rd_valid, 0, "buffer empty");
    access(1'b1, 24'h00_0abc, {9{8'ha5}}, ok);
    check(rd_valid, 0, "store leaves buffer empty");
    check(n_dreq, FIFO_DEPTH + 1, "one data request per storage access");
    report_and_stop();
  end
endmodule : tb_storage_port_adapter
